// >>> verilog/pehx_pkg.sv
// =============================================================================
// Shared constants and carriers of the position entry executor.
package pehx_pkg;

  // ===========================================================================
  // Timing.
  localparam int CLK_PERIOD_NS = 40;                         // Core clock period.
  localparam int MS_NS         = 1000000;                    // One millisecond in ns.
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;      // Cycles per millisecond.
  localparam int WAKE_NS       = 320;                        // Servo wake-up settle time.
  localparam int WAKE_CYCLES   = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WAKE_CNT = 4'(WAKE_CYCLES);         // Wake count in four bits, zero-extended to the 16-bit counter.

  // ===========================================================================
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL      = 8'h00;  // Command and alarm clear strobes.
  localparam logic [7:0] ADDR_POS       = 8'h04;  // Stored target position.
  localparam logic [7:0] ADDR_BAND      = 8'h08;  // Signed band distance.
  localparam logic [7:0] ADDR_MODE      = 8'h0c;  // Entry mode fields.
  localparam logic [7:0] ADDR_PUSH_SPD  = 8'h10;  // Push speed parameter.
  localparam logic [7:0] ADDR_JUDGE     = 8'h14;  // Push completion judgment time, ms.
  localparam logic [7:0] ADDR_DELAY_A   = 8'h18;  // Servo-off delay for code 1, ms.
  localparam logic [7:0] ADDR_DELAY_B   = 8'h1c;  // Servo-off delay for codes 2 and 3, ms.
  localparam logic [7:0] ADDR_STATUS    = 8'h20;  // Live status, read only.
  localparam logic [7:0] ADDR_POS_FB    = 8'h24;  // Current position, read only.

  // ===========================================================================
  // Field positions and values.
  localparam int CTRL_GO_BIT    = 0;              // Write one to start the entry.
  localparam int CTRL_CLR_BIT   = 1;              // Write one to clear the alarm.
  localparam int MODE_W         = 14;             // Used width of the mode register.
  localparam logic [7:0]  PUSH_NONE  = 8'h00;     // Push value selecting plain positioning.
  localparam logic [2:0]  SS_OFF     = 3'h0;      // No power saving.
  localparam logic [2:0]  SS_AUTO_A  = 3'h1;      // Auto servo-off, first delay.
  localparam logic [2:0]  SS_AUTO_C  = 3'h3;      // Last auto servo-off code.
  localparam logic [2:0]  SS_FULL    = 3'h4;      // Full servo control holding.
  localparam logic [31:0] ZERO32     = 32'h0000_0000;
  localparam logic [15:0] ZERO16     = 16'h0000;
  localparam logic [15:0] ONE16      = 16'h0001;

  // ===========================================================================
  // Entry mode register layout, most significant field first.
  typedef struct packed {
    logic       cmd_mode;     // Unused, kept for readback.
    logic       accel_mode;   // Unused, kept for readback.
    logic [2:0] standstill;   // Power saving code.
    logic       incremental;  // Relative target when set.
    logic [7:0] push;         // Current limit percent, zero for positioning.
  } pehx_mode_t;

  // Command bundle toward the motor drive.
  typedef struct packed {
    logic signed [31:0] target;      // Position the drive steers to.
    logic               push_mode;   // Run at push speed under current limit.
    logic [15:0]        push_speed;  // Speed used in push mode.
    logic [7:0]         cur_limit;   // Current limit percent, zero for none.
    logic               servo_on;    // Servo energised.
    logic               hold_reduce; // Reduced holding current at standstill.
  } pehx_drive_t;

  // Status word layout.
  typedef struct packed {
    logic [25:0] rsvd;        // Reads as zero.
    logic        hold_reduce; // Reduced holding current active.
    logic        missed;      // Band travelled without contact.
    logic        alarm;       // Servo error alarm.
    logic        servo_on;    // Servo energised.
    logic        moving;      // Motion in progress.
    logic        complete;    // Position complete.
  } pehx_status_t;

endpackage : pehx_pkg

// >>> verilog/pehx_sync.sv
`timescale 1ns/1ps
`default_nettype none
// =============================================================================
// Three-stage input synchroniser with agreement filter.
module pehx_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1_q;     // First stage, read only by the second stage.
  logic s2_q;     // Second stage.
  logic s3_q;     // Third stage.
  logic lvl_q;    // Filtered level.
  logic lvl_d;    // Next filtered level.

  // The filtered level only moves once the second and third stages agree.
  always_comb begin
    lvl_d = lvl_q;
    if (s2_q == s3_q) begin
      lvl_d = s3_q;
    end
  end

  // Register the stages.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q  <= pin_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;

endmodule : pehx_sync
`default_nettype wire

// >>> verilog/pehx_executor.sv
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module pehx_executor
  import pehx_pkg::*;
#(
  parameter int MS_TICK = MS_CYCLES   // Cycles per millisecond tick.
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic [7:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic               plc_start,
  input  wire logic signed [31:0] pos_fb,
  input  wire logic [7:0]         motor_cur,
  output pehx_drive_t             drive,
  output logic                    pos_complete,
  output logic                    moving,
  output logic                    servo_alarm
);

  // ===========================================================================
  // Declarations.
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAKE, ST_MOVE, ST_PUSH, ST_HOLD, ST_DONE, ST_ALARM
  } pehx_state_t;

  logic               start_lvl;                   // Filtered command pin.
  logic               start_lvl_q;                 // Previous filtered level.
  logic               start_evt;                   // Rising edge of the command.
  logic [31:0]        tick_cnt_q,  tick_cnt_d;     // Millisecond prescaler.
  logic               tick;                        // One-cycle millisecond tick.
  logic               wait_q,      wait_d;         // Bus wait state.
  logic [31:0]        rdata_q,     rdata_d;        // Bus read data.
  logic signed [31:0] pos_q,       pos_d;          // Stored target.
  logic signed [31:0] band_q,      band_d;         // Stored band.
  pehx_mode_t         mode_q,      mode_d;         // Stored mode fields.
  logic [15:0]        pspd_q,      pspd_d;         // Push speed.
  logic [15:0]        judge_q,     judge_d;        // Judgment time in ms.
  logic [15:0]        dly_a_q,     dly_a_d;        // First servo-off delay.
  logic [15:0]        dly_b_q,     dly_b_d;        // Second servo-off delay.
  logic               go_wr;                       // Software start strobe.
  logic               clr_wr;                      // Software alarm clear strobe.
  pehx_status_t       status;                      // Assembled status word.
  pehx_state_t        st_q,        st_d;           // Sequencer state.
  pehx_mode_t         run_q,       run_d;          // Mode snapshot of the running entry.
  logic signed [31:0] tgt_q,       tgt_d;          // Resolved target.
  logic signed [31:0] bend_q,      bend_d;         // Push end position.
  logic [15:0]        cnt_q,       cnt_d;          // Wait and delay counter.
  logic               missed_q,    missed_d;       // Work part missed.
  logic               bus_acc;                     // Access taken this edge.
  logic               cur_at_lim;                  // Current reached the limit.
  pehx_drive_t        drv_q,       drv_d;          // Drive command.
  logic               pend_q,      pend_d;         // Position complete.
  logic               move_q,      move_d;         // Motion flag.
  logic               alarm_q,     alarm_d;        // Servo error alarm output register.

  // ===========================================================================
  // Command input.
  pehx_sync u_start_sync (
    .core_clk  (core_clk),
    .rst       (rst),
    .pin_in    (plc_start),
    .level_out (start_lvl)
  );

  // Edge of the filtered pin or a software strobe starts the entry.
  assign start_evt = (start_lvl & ~start_lvl_q) | go_wr;

  // ===========================================================================
  // Millisecond prescaler for the judgment and delay times.
  always_comb begin
    tick_cnt_d = tick_cnt_q + 32'h0000_0001;
    tick       = 1'b0;
    if (tick_cnt_q >= 32'(MS_TICK - 1)) begin
      tick_cnt_d = ZERO32;
      tick       = 1'b1;
    end
  end

  // Register the prescaler and the pin edge history.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q  <= ZERO32;
      start_lvl_q <= 1'b0;
    end else begin
      tick_cnt_q  <= tick_cnt_d;
      start_lvl_q <= start_lvl;
    end
  end

  // ===========================================================================
  // Avalon-MM slave. Wait drops for one cycle after a request is seen.
  assign bus_acc = (avs_read | avs_write) & ~wait_q;
  assign go_wr   = bus_acc & avs_write & (avs_address == ADDR_CTRL) &
                   avs_writedata[CTRL_GO_BIT];
  assign clr_wr  = bus_acc & avs_write & (avs_address == ADDR_CTRL) &
                   avs_writedata[CTRL_CLR_BIT];

  // Status word from the sequencer state.
  always_comb begin
    status             = '0;
    status.complete    = pend_q;
    status.moving      = move_q;
    status.servo_on    = drv_q.servo_on;
    status.alarm       = (st_q == ST_ALARM);
    status.missed      = missed_q;
    status.hold_reduce = drv_q.hold_reduce;
  end

  // Bus next values: wait state, read mux and register writes.
  always_comb begin
    wait_d  = ~((avs_read | avs_write) & wait_q);
    rdata_d = rdata_q;
    pos_d   = pos_q;
    band_d  = band_q;
    mode_d  = mode_q;
    pspd_d  = pspd_q;
    judge_d = judge_q;
    dly_a_d = dly_a_q;
    dly_b_d = dly_b_q;
    // Read data is prepared while waitrequest is still high.
    if (avs_read & wait_q) begin
      unique case (avs_address)
        ADDR_POS:      rdata_d = pos_q;
        ADDR_BAND:     rdata_d = band_q;
        ADDR_MODE:     rdata_d = {18'h0_0000, mode_q};
        ADDR_PUSH_SPD: rdata_d = {ZERO16, pspd_q};
        ADDR_JUDGE:    rdata_d = {ZERO16, judge_q};
        ADDR_DELAY_A:  rdata_d = {ZERO16, dly_a_q};
        ADDR_DELAY_B:  rdata_d = {ZERO16, dly_b_q};
        ADDR_STATUS:   rdata_d = status;
        ADDR_POS_FB:   rdata_d = pos_fb;
        default:       rdata_d = ZERO32;
      endcase
    end
    // Writes take effect on the edge that sees waitrequest low.
    if (bus_acc & avs_write) begin
      unique case (avs_address)
        ADDR_POS:      pos_d   = avs_writedata;
        ADDR_BAND:     band_d  = avs_writedata;
        ADDR_MODE:     mode_d  = avs_writedata[MODE_W-1:0];
        ADDR_PUSH_SPD: pspd_d  = avs_writedata[15:0];
        ADDR_JUDGE:    judge_d = avs_writedata[15:0];
        ADDR_DELAY_A:  dly_a_d = avs_writedata[15:0];
        ADDR_DELAY_B:  dly_b_d = avs_writedata[15:0];
        default:       ;
      endcase
    end
  end

  // Register the bus state.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_q  <= 1'b1;
      rdata_q <= ZERO32;
      pos_q   <= ZERO32;
      band_q  <= ZERO32;
      mode_q  <= '0;
      pspd_q  <= ZERO16;
      judge_q <= ZERO16;
      dly_a_q <= ZERO16;
      dly_b_q <= ZERO16;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      pos_q   <= pos_d;
      band_q  <= band_d;
      mode_q  <= mode_d;
      pspd_q  <= pspd_d;
      judge_q <= judge_d;
      dly_a_q <= dly_a_d;
      dly_b_q <= dly_b_d;
    end
  end

  // ===========================================================================
  // Sequencer.
  assign cur_at_lim = (motor_cur >= run_q.push);

  // Next values of the sequencer, the drive command and the outputs.
  always_comb begin
    st_d     = st_q;
    run_d    = run_q;
    tgt_d    = tgt_q;
    bend_d   = bend_q;
    cnt_d    = cnt_q;
    missed_d = missed_q;
    drv_d    = drv_q;
    pend_d   = pend_q;
    move_d   = move_q;
    unique case (st_q)
      ST_IDLE, ST_DONE, ST_HOLD: begin
        // Standstill power saving after a finished move.
        if (st_q == ST_DONE) begin
          if (run_q.standstill == SS_FULL) begin
            drv_d.hold_reduce = 1'b1;
          end else if ((run_q.standstill >= SS_AUTO_A) &&
                       (run_q.standstill <= SS_AUTO_C) && drv_q.servo_on) begin
            // Code 1 uses the first delay, codes 2 and 3 the second.
            if (cnt_q >= ((run_q.standstill == SS_AUTO_A) ? dly_a_q : dly_b_q)) begin
              drv_d.servo_on = 1'b0;
            end else if (tick) begin
              cnt_d = cnt_q + ONE16;
            end
          end
        end
        // While holding a push, complete follows the motor current.
        if (st_q == ST_HOLD) begin
          pend_d = cur_at_lim;
        end
        if (start_evt) begin
          // Only accel and command mode bits are dropped from use.
          run_d = mode_q;
          // Relative entries add to the present position.
          tgt_d  = mode_q.incremental ? (pos_fb + pos_q) : pos_q;
          bend_d = (mode_q.incremental ? (pos_fb + pos_q) : pos_q) + band_q;
          cnt_d    = ZERO16;
          pend_d   = 1'b0;
          missed_d = 1'b0;
          move_d   = 1'b1;
          drv_d.hold_reduce = 1'b0;
          drv_d.push_mode   = 1'b0;
          drv_d.cur_limit   = PUSH_NONE;
          if (!drv_q.servo_on) begin
            drv_d.servo_on = 1'b1;
            st_d           = ST_WAKE;
          end else begin
            drv_d.target = mode_q.incremental ? (pos_fb + pos_q) : pos_q;
            st_d         = ST_MOVE;
          end
        end
      end
      ST_WAKE: begin
        // Let the servo settle before the move begins.
        if (cnt_q >= {12'h000, WAKE_CNT}) begin
          drv_d.target = tgt_q;
          cnt_d        = ZERO16;
          st_d         = ST_MOVE;
        end else begin
          cnt_d = cnt_q + ONE16;
        end
      end
      ST_MOVE: begin
        if ((run_q.push != PUSH_NONE) && cur_at_lim && (pos_fb != tgt_q)) begin
          // Contact before the target is a servo error.
          drv_d.servo_on = 1'b0;
          move_d         = 1'b0;
          st_d           = ST_ALARM;
        end else if (pos_fb == tgt_q) begin
          cnt_d = ZERO16;
          if (run_q.push == PUSH_NONE) begin
            pend_d = 1'b1;
            move_d = 1'b0;
            st_d   = ST_DONE;
          end else begin
            // Continue toward the band end at push speed, current limited.
            drv_d.target     = bend_q;
            drv_d.push_mode  = 1'b1;
            drv_d.push_speed = pspd_q;
            drv_d.cur_limit  = run_q.push;
            st_d             = ST_PUSH;
          end
        end
      end
      ST_PUSH: begin
        if (cur_at_lim) begin
          // Current must stay at the limit for the judgment time.
          if (cnt_q >= judge_q) begin
            pend_d = 1'b1;
            move_d = 1'b0;
            st_d   = ST_HOLD;
          end else if (tick) begin
            cnt_d = cnt_q + ONE16;
          end
        end else begin
          cnt_d = ZERO16;
          if (pos_fb == bend_q) begin
            // Band used up without contact: stop there, complete stays low.
            missed_d = 1'b1;
            move_d   = 1'b0;
            st_d     = ST_DONE;
          end
        end
      end
      ST_ALARM: begin
        if (clr_wr) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    alarm_d = (st_d == ST_ALARM);
  end

  // Register the sequencer.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q     <= ST_IDLE;
      run_q    <= '0;
      tgt_q    <= ZERO32;
      bend_q   <= ZERO32;
      cnt_q    <= ZERO16;
      missed_q <= 1'b0;
      drv_q    <= '0;
      pend_q   <= 1'b0;
      move_q   <= 1'b0;
      alarm_q  <= 1'b0;
    end else begin
      st_q     <= st_d;
      run_q    <= run_d;
      tgt_q    <= tgt_d;
      bend_q   <= bend_d;
      cnt_q    <= cnt_d;
      missed_q <= missed_d;
      drv_q    <= drv_d;
      pend_q   <= pend_d;
      move_q   <= move_d;
      alarm_q  <= alarm_d;
    end
  end

  // ===========================================================================
  // Outputs, each straight from a flip-flop.
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign drive           = drv_q;
  assign pos_complete    = pend_q;
  assign moving          = move_q;
  assign servo_alarm     = alarm_q;

endmodule : pehx_executor
`default_nettype wire

// >>> testbench/pehx_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// =============================================================================
// Motor drive and work part: steps one unit a cycle toward the target and
// stalls against the part, where the current climbs to the limit in force.
module pehx_drive_model
  import pehx_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire pehx_drive_t        drive,
  input  wire logic signed [31:0] wall,
  output logic signed [31:0]      pos_fb,
  output logic [7:0]              motor_cur
);
  logic blocked;  // Forward travel is stopped by the part.
  assign blocked = drive.servo_on && drive.target > pos_fb && pos_fb >= wall;
  // Position follows the target; a stronger part pushes the carriage back.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pos_fb    <= 32'sh0;
      motor_cur <= 8'h00;
    end else begin
      if (pos_fb > wall) begin
        pos_fb <= wall;
      end else if (drive.servo_on && !blocked && drive.target != pos_fb) begin
        pos_fb <= (drive.target > pos_fb) ? pos_fb + 1 : pos_fb - 1;
      end
      motor_cur <= !blocked ? 8'h05 : (drive.push_mode ? drive.cur_limit : 8'h64);
    end
  end
endmodule : pehx_drive_model
`default_nettype wire

// >>> testbench/pehx_executor_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// =============================================================================
// Checker on the executor ports.
module pehx_executor_asserts
  import pehx_pkg::*;
#(
  parameter int MS_TICK = MS_CYCLES  // Cycles per millisecond tick.
) (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic [7:0]         avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest,
  input wire logic               plc_start,
  input wire logic signed [31:0] pos_fb,
  input wire logic [7:0]         motor_cur,
  input wire pehx_drive_t        drive,
  input wire logic               pos_complete,
  input wire logic               moving,
  input wire logic               servo_alarm
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop after a request");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest stayed low");
  chk_wake_hold: assert property ($rose(drive.servo_on) |-> moving ##0 $stable(drive.target)[*7])
    else $error("target moved during servo wake");
  chk_hold_reduce: assert property (drive.hold_reduce |-> drive.servo_on && !moving && pos_complete)
    else $error("reduced holding outside standstill");
  chk_plain_done: assert property ($rose(pos_complete) && !drive.push_mode |-> !moving && pos_fb == drive.target)
    else $error("complete away from target");
  chk_push_done: assert property ($rose(pos_complete) && drive.push_mode |-> $past(motor_cur) >= drive.cur_limit)
    else $error("push complete without current at limit");
  chk_alarm_cause: assert property ($rose(servo_alarm) |-> !drive.servo_on && $past(pos_fb) != $past(drive.target))
    else $error("alarm without early contact");
  chk_cur_drop: assert property (pos_complete && drive.push_mode && motor_cur < drive.cur_limit |=> !pos_complete)
    else $error("complete kept with low current");
  chk_cur_resume: assert property (drive.push_mode && $fell(pos_complete) ##[1:200] motor_cur >= drive.cur_limit |=> pos_complete)
    else $error("complete not restored");
  chk_push_keep: assert property (pos_complete && drive.push_mode && motor_cur >= drive.cur_limit |=> pos_complete)
    else $error("complete lost while at limit");
  chk_push_limit: assert property (drive.push_mode |-> drive.cur_limit != PUSH_NONE)
    else $error("push mode without current limit");
endmodule : pehx_executor_asserts
bind pehx_executor pehx_executor_asserts #(.MS_TICK(MS_TICK)) u_chk (.core_clk(core_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .plc_start(plc_start), .pos_fb(pos_fb), .motor_cur(motor_cur), .drive(drive),
  .pos_complete(pos_complete), .moving(moving), .servo_alarm(servo_alarm));
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
// =============================================================================
// Bench: registers over the bus, entries started by pin and by command.
module tb
  import pehx_pkg::*;
;
  localparam int          TICK  = 4;      // Short millisecond for simulation.
  localparam logic [31:0] DLY_A = 32'h3;  // Servo-off delay of code 1, ms.
  localparam logic [31:0] DLY_B = 32'h6;  // Servo-off delay of codes 2 and 3, ms.
  localparam logic [31:0] JUDGE = 32'h2;  // Push completion time, ms.
  logic               core_clk, rst, plc_start, pos_complete, moving, servo_alarm;
  logic               avs_read, avs_write, avs_waitrequest;
  logic [7:0]         avs_address, motor_cur;
  logic [31:0]        avs_writedata, avs_readdata, rd_q[$], tgt_q[$];
  logic signed [31:0] pos_fb, wall, last_t, tgt;
  pehx_drive_t        drive;
  int                 mismatches, compares, n, d;
  pehx_executor #(.MS_TICK(TICK)) u_dut (.core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .plc_start(plc_start), .pos_fb(pos_fb),
    .motor_cur(motor_cur), .drive(drive), .pos_complete(pos_complete), .moving(moving),
    .servo_alarm(servo_alarm));
  pehx_drive_model u_drv (.core_clk(core_clk), .rst(rst), .drive(drive), .wall(wall),
    .pos_fb(pos_fb), .motor_cur(motor_cur));
  always #20 core_clk = !core_clk;
  task automatic end_sim();
    $display("Mismatches %0d, compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_flag(input logic got);
    compares++;
    if (got !== 1'b1) begin
      mismatches++;
      $display("ERROR at %0t: condition not met", $time);
    end
  endtask : cmp_flag
  // One bus transfer; a read notes its expected word for the monitor.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v);
    if (!wr) begin
      rd_q.push_back(v);
    end
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= wr ? v : 32'h0;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  function automatic logic pick(input int s);
    case (s)
      0: return pos_complete;
      1: return drive.servo_on;
      2: return servo_alarm;
      3: return drive.hold_reduce;
      4: return pos_fb == wall;
      default: return moving;
    endcase
  endfunction : pick
  // Waits for a flag to reach a level, counting the cycles in n.
  task automatic wait_on(input int s, input logic lvl);
    n = 0;
    while (pick(s) !== lvl && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    cmp_flag(n < 3000);
  endtask : wait_on
  // Starts the entry by pin or by command and waits for motion.
  task automatic start(input logic by_pin);
    if (by_pin) begin
      plc_start <= 1'b1;
      repeat (6) @(posedge core_clk);
      plc_start <= 1'b0;
    end else begin
      bus(1'b1, ADDR_CTRL, 32'h1);
    end
    wait_on(5, 1'b1);
  endtask : start
  // Takes the oldest note when a read is answered or the target moves.
  always @(posedge core_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      cmp_word(avs_readdata, rd_q.pop_front());
    end
    if (!rst && drive.servo_on && drive.target !== last_t) begin
      cmp_word(drive.target, tgt_q.size() > 0 ? tgt_q.pop_front() : 32'hx);
    end
    last_t = drive.target;
  end
  // Watchdog: the sequence needs well under this many cycles.
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    $display("ERROR at %0t: timeout", $time);
    end_sim();
  end
  // =============================================================================
  // Main sequence.
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {plc_start, avs_read, avs_write, avs_address, avs_writedata} = '0;
    wall = 32'sh7fff_0000;
    last_t = 32'sh0;
    mismatches = 0;
    compares = 0;
    d = $urandom(75367);
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bus(1'b0, ADDR_STATUS, 32'h0);
    bus(1'b0, 8'h3c, 32'h0);
    bus(1'b1, ADDR_STATUS, 32'hff);
    bus(1'b0, ADDR_STATUS, 32'h0);
    bus(1'b1, ADDR_DELAY_A, DLY_A);
    bus(1'b1, ADDR_DELAY_B, DLY_B);
    bus(1'b1, ADDR_JUDGE, JUDGE);
    bus(1'b1, ADDR_PUSH_SPD, 32'h14);
    for (int c = 0; c < 5; c++) begin
      d = $urandom_range(15, 1);
      tgt = (c == 2) ? last_t + d : 32'(20 * c + 40 + d);
      tgt_q.push_back(tgt);
      bus(1'b1, ADDR_POS, (c == 2) ? 32'(d) : tgt);
      bus(1'b1, ADDR_MODE, {18'h0, 2'b11, 3'(c), c == 2, 8'h00});
      bus(1'b0, ADDR_MODE, {18'h0, 2'b11, 3'(c), c == 2, 8'h00});
      start(c[0]);
      wait_on(0, 1'b1);
      if (c == 0) begin
        bus(1'b0, ADDR_STATUS, 32'h5);
      end else if (c < 4) begin
        d = (c == 1) ? DLY_A : DLY_B;
        wait_on(1, 1'b0);
        cmp_flag(n >= (d - 1) * TICK && n <= (d + 1) * TICK + 4);
      end else begin
        wait_on(3, 1'b1);
        bus(1'b0, ADDR_STATUS, 32'h25);
      end
    end
    wall <= 32'sh96;
    tgt_q.push_back(32'hc8);
    bus(1'b1, ADDR_POS, 32'hc8);
    bus(1'b1, ADDR_MODE, 32'h32);
    start(1'b0);
    wait_on(2, 1'b1);
    bus(1'b0, ADDR_STATUS, 32'h8);
    bus(1'b1, ADDR_CTRL, 32'h1);
    bus(1'b0, ADDR_STATUS, 32'h8);
    bus(1'b1, ADDR_CTRL, 32'h2);
    bus(1'b0, ADDR_STATUS, 32'h0);
    wall <= 32'sh7fff_0000;
    tgt_q.push_back(32'hd2);
    tgt_q.push_back(32'hbe);
    bus(1'b1, ADDR_POS, 32'hd2);
    bus(1'b1, ADDR_BAND, 32'hffff_ffec);
    start(1'b1);
    wait_on(5, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h14);
    bus(1'b0, ADDR_POS_FB, 32'hbe);
    wall <= 32'sh104;
    tgt_q.push_back(32'hfa);
    tgt_q.push_back(32'h118);
    bus(1'b1, ADDR_POS, 32'hfa);
    bus(1'b1, ADDR_BAND, 32'h1e);
    start(1'b0);
    wait_on(4, 1'b1);
    wait_on(0, 1'b1);
    cmp_flag(n >= (JUDGE - 1) * TICK && n <= (JUDGE + 1) * TICK + 4);
    cmp_word({drive.push_mode, drive.push_speed, drive.cur_limit}, {1'b1, 16'h14, 8'h32});
    wall <= 32'sh10e;
    wait_on(0, 1'b0);
    wait_on(0, 1'b1);
    bus(1'b0, ADDR_POS_FB, 32'h10e);
    wall <= 32'sh109;
    repeat (20) @(posedge core_clk);
    cmp_flag(pos_complete);
    bus(1'b0, ADDR_POS_FB, 32'h109);
    end_sim();
  end
endmodule : tb
`default_nettype wire
